// file: rtl/acsp_i2c_slave.sv
// Two-wire control slave port: framing, addressing and register transfers.
`timescale 1ns/100ps
`default_nettype none
`include "acsp_cfg.svh"
module acsp_i2c_slave import acsp_pkg::*; (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         ce,
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	input  wire logic         addr_sel,
	output logic              sda_out,
	output logic              sda_oe,
	output logic              wr_valid,
	output logic [7:0]        wr_addr,
	output logic [2:0]        wr_words,
	output logic [159:0]      wr_data,
	output logic [7:0]        rd_addr,
	output logic [2:0]        rd_word_idx,
	input  wire logic [31:0]  rd_word,
	output logic [6:0]        dev_addr,
	output logic              busy
);
	// Words per set; zero means one plain byte per subaddress.
	function automatic logic [2:0] set_words(input logic [7:0] sub);
		if (sub < `ACSP_SUB_WIDE_LO)
			set_words = 3'h0;
		else if (sub >= `ACSP_SUB_BIQ_LO && sub <= `ACSP_SUB_BIQ_HI)
			set_words = `ACSP_BIQ_WORDS;
		else
			set_words = 3'h1;
	endfunction : set_words

	function automatic logic [4:0] set_bytes(input logic [7:0] sub);
		logic [2:0] w;
		w = set_words(sub);
		set_bytes = (w == 3'h0) ? 5'h01 : {w, 2'b00};
	endfunction : set_bytes

	acsp_state_e          state_r;
	logic                 scl_m, scl_s, scl_d;
	logic                 sda_m, sda_s, sda_d;
	logic                 asel_m, asel_s;
	logic [1:0]           strap_cnt_r;
	logic [3:0]           bitcnt_r;
	logic [7:0]           shreg_r;
	logic [7:0]           tx_r;
	logic                 rw_r;
	logic [7:0]           sub_r;
	logic [4:0]           bcnt_r;
	logic [1:0]           rbyte_r;
	logic [2:0]           rword_r;
	logic [`ACSP_WBUF_BITS-1:0] wacc_r;
	logic [`ACSP_WBUF_BITS-1:0] wacc_nxt;
	logic                 unlock_r;
	logic [7:0]           rd_byte;
	logic                 start_det, stop_det, scl_rise, scl_fall;
	logic                 byte_done, set_done, sub_done, rack_ok;

	assign sda_out = 1'b0;
	assign busy = (state_r != ACSP_IDLE);
	assign rd_addr = sub_r;
	assign rd_word_idx = rword_r;

	// Pins cross into clk through two flops before anything reads them.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_m  <= 1'b1;
			scl_s  <= 1'b1;
			scl_d  <= 1'b1;
			sda_m  <= 1'b1;
			sda_s  <= 1'b1;
			sda_d  <= 1'b1;
			asel_m <= 1'b0;
			asel_s <= 1'b0;
		end else if (ce) begin
			scl_m  <= scl_in;
			scl_s  <= scl_m;
			scl_d  <= scl_s;
			sda_m  <= sda_in;
			sda_s  <= sda_m;
			sda_d  <= sda_s;
			asel_m <= addr_sel;
			asel_s <= asel_m;
		end
	end

	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
	assign scl_rise  = scl_s && !scl_d;
	assign scl_fall  = !scl_s && scl_d;
	assign byte_done = (state_r == ACSP_WDATA) && scl_fall && bitcnt_r == 4'h8;
	assign sub_done  = (state_r == ACSP_SUB) && scl_fall && bitcnt_r == 4'h8;
	assign set_done  = byte_done && (bcnt_r + 5'h01 == set_bytes(sub_r));
	assign rack_ok   = (state_r == ACSP_RACK) && scl_rise && !sda_s;
	assign wacc_nxt  = {wacc_r[`ACSP_WBUF_BITS-9:0], shreg_r};

	// Narrow registers come from the low byte; unused bits read zero.
	always_comb begin
		if (sub_r == `ACSP_SUB_NEWADDR)
			rd_byte = (rbyte_r == 2'h3) ? {dev_addr, 1'b0} : 8'h00;
		else if (set_words(sub_r) == 3'h0)
			rd_byte = rd_word[7:0];
		else begin
			unique case (rbyte_r)
				2'h0: rd_byte = rd_word[31:24];
				2'h1: rd_byte = rd_word[23:16];
				2'h2: rd_byte = rd_word[15:8];
				2'h3: rd_byte = rd_word[7:0];
			endcase
		end
	end

	// Bus framing. The clock line is never driven: no wait states.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r  <= ACSP_IDLE;
			bitcnt_r <= 4'h0;
			shreg_r  <= 8'h00;
			tx_r     <= 8'h00;
			rw_r     <= 1'b0;
			sda_oe   <= 1'b0;
		end else if (ce) begin
			if (start_det) begin
				state_r  <= ACSP_ADDR;
				bitcnt_r <= 4'h0;
				sda_oe   <= 1'b0;
			end else if (stop_det) begin
				state_r <= ACSP_IDLE;
				sda_oe  <= 1'b0;
			end else begin
				unique case (state_r)
					ACSP_IDLE: begin
					end
					ACSP_ADDR, ACSP_SUB, ACSP_WDATA: begin
						if (scl_rise && bitcnt_r != 4'h8) begin
							shreg_r  <= {shreg_r[6:0], sda_s};
							bitcnt_r <= bitcnt_r + 4'h1;
						end
						if (scl_fall && bitcnt_r == 4'h8) begin
							bitcnt_r <= 4'h0;
							if (state_r == ACSP_ADDR) begin
								if (shreg_r[7:1] == dev_addr) begin
									state_r <= ACSP_ADDR_ACK;
									sda_oe  <= 1'b1;
									rw_r    <= shreg_r[0];
								end else
									state_r <= ACSP_IDLE;
							end else if (state_r == ACSP_SUB) begin
								state_r <= ACSP_SUB_ACK;
								sda_oe  <= 1'b1;
							end else begin
								state_r <= ACSP_WDATA_ACK;
								sda_oe  <= 1'b1;
							end
						end
					end
					ACSP_ADDR_ACK: begin
						if (scl_fall) begin
							if (rw_r) begin
								state_r <= ACSP_RDATA;
								tx_r    <= rd_byte;
								sda_oe  <= !rd_byte[7];
							end else begin
								state_r <= ACSP_SUB;
								sda_oe  <= 1'b0;
							end
						end
					end
					ACSP_SUB_ACK, ACSP_WDATA_ACK: begin
						if (scl_fall) begin
							state_r <= ACSP_WDATA;
							sda_oe  <= 1'b0;
						end
					end
					ACSP_RDATA: begin
						if (scl_fall) begin
							if (bitcnt_r == 4'h7) begin
								state_r  <= ACSP_RACK;
								bitcnt_r <= 4'h0;
								sda_oe   <= 1'b0;
							end else begin
								tx_r     <= {tx_r[6:0], 1'b0};
								sda_oe   <= !tx_r[6];
								bitcnt_r <= bitcnt_r + 4'h1;
							end
						end
					end
					ACSP_RACK: begin
						if (scl_rise && sda_s)
							state_r <= ACSP_IDLE;
						else if (scl_fall) begin
							state_r <= ACSP_RDATA;
							tx_r    <= rd_byte;
							sda_oe  <= !rd_byte[7];
						end
					end
				endcase
			end
		end
	end

	// Subaddress walk and set assembly; partial sets die at start or stop.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sub_r   <= 8'h00;
			bcnt_r  <= 5'h00;
			rbyte_r <= 2'h0;
			rword_r <= 3'h0;
			wacc_r  <= '0;
		end else if (ce) begin
			if (start_det || stop_det) begin
				bcnt_r <= 5'h00;
				wacc_r <= '0;
			end else if (sub_done) begin
				sub_r   <= shreg_r;
				bcnt_r  <= 5'h00;
				rbyte_r <= 2'h0;
				rword_r <= 3'h0;
			end else if (byte_done) begin
				if (set_done) begin
					bcnt_r <= 5'h00;
					wacc_r <= '0;
					sub_r  <= sub_r + 8'h01;
				end else begin
					bcnt_r <= bcnt_r + 5'h01;
					wacc_r <= wacc_nxt;
				end
			end else if (rack_ok) begin
				if (set_words(sub_r) == 3'h0)
					sub_r <= sub_r + 8'h01;
				else if (rbyte_r != 2'h3)
					rbyte_r <= rbyte_r + 2'h1;
				else begin
					rbyte_r <= 2'h0;
					if (rword_r + 3'h1 == set_words(sub_r)) begin
						rword_r <= 3'h0;
						sub_r   <= sub_r + 8'h01;
					end else
						rword_r <= rword_r + 3'h1;
				end
			end
		end
	end

	// Completed sets go out as one pulse; the two address registers stay here.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_valid <= 1'b0;
			wr_addr  <= 8'h00;
			wr_words <= 3'h0;
			wr_data  <= '0;
		end else if (ce) begin
			wr_valid <= set_done && sub_r != `ACSP_SUB_UNLOCK
				&& sub_r != `ACSP_SUB_NEWADDR;
			if (set_done) begin
				wr_addr  <= sub_r;
				wr_words <= set_words(sub_r);
				wr_data  <= wacc_nxt;
			end
		end
	end

	// The strap is caught a few cycles after release, once the sync settles.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strap_cnt_r <= 2'h0;
			dev_addr    <= 7'h00;
			unlock_r    <= 1'b0;
		end else if (ce) begin
			if (strap_cnt_r != `ACSP_STRAP_WAIT) begin
				strap_cnt_r <= strap_cnt_r + 2'h1;
				dev_addr <= asel_s ? `ACSP_ADDR_PULLUP
					: `ACSP_ADDR_PULLDOWN;
			end else if (set_done && sub_r == `ACSP_SUB_UNLOCK)
				unlock_r <= (wacc_nxt[31:0] == `ACSP_UNLOCK_KEY);
			else if (set_done && sub_r == `ACSP_SUB_NEWADDR) begin
				if (unlock_r)
					dev_addr <= shreg_r[7:1];
				unlock_r <= 1'b0;
			end
		end
	end

	default clocking acsp_cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	start_goes_addr_a: assert property (ce && start_det |=> state_r == ACSP_ADDR)
		else $error("start not followed by address phase");
	stop_goes_idle_a: assert property (ce && stop_det |=> state_r == ACSP_IDLE)
		else $error("stop not followed by idle");
	ack_held_low_a: assert property (state_r inside {ACSP_ADDR_ACK, ACSP_SUB_ACK, ACSP_WDATA_ACK} |-> sda_oe)
		else $error("acknowledge not driven low");
	oe_moves_low_a: assert property ($changed(sda_oe) && !$past(start_det) && !$past(stop_det) |-> !scl_s)
		else $error("data line changed while clock high");
	nomatch_release_a: assert property (ce && state_r == ACSP_ADDR && scl_fall && bitcnt_r == 4'h8 && shreg_r[7:1] != dev_addr && !start_det && !stop_det |=> state_r == ACSP_IDLE && !sda_oe)
		else $error("unmatched address acknowledged");
	partial_dropped_a: assert property (start_det || stop_det |=> !wr_valid)
		else $error("partial set committed");
	wide_whole_words_a: assert property (wr_valid && wr_addr >= `ACSP_SUB_WIDE_LO |-> wr_words != 3'h0)
		else $error("wide subaddress written without whole words");
	read_bit_out_a: assert property (state_r == ACSP_RDATA |-> sda_oe == !tx_r[7])
		else $error("read bit not msb of shift register");
	eight_bits_a: assert property (state_r == ACSP_WDATA ##1 state_r == ACSP_WDATA_ACK |-> $past(bitcnt_r) == 4'h8)
		else $error("acknowledge before eight bits");
	write_commit_c: cover property (wr_valid);
	read_ack_c: cover property (rack_ok);
	addr_change_c: cover property (ce && set_done && sub_r == `ACSP_SUB_NEWADDR && unlock_r);
endmodule : acsp_i2c_slave
`default_nettype wire

// file: include/acsp_cfg.svh
// Constants for the two-wire control slave port.
`ifndef ACSP_CFG_SVH
`define ACSP_CFG_SVH
`define ACSP_ADDR_PULLDOWN 7'h1a
`define ACSP_ADDR_PULLUP   7'h1b
`define ACSP_SUB_UNLOCK    8'hf8
`define ACSP_SUB_NEWADDR   8'hf9
`define ACSP_UNLOCK_KEY    32'hf9a5a5a5
`define ACSP_SUB_WIDE_LO   8'h20
`define ACSP_SUB_BIQ_LO    8'h29
`define ACSP_SUB_BIQ_HI    8'h36
`define ACSP_BIQ_WORDS     3'h5
`define ACSP_STRAP_WAIT    2'h3
`define ACSP_WBUF_BITS     160
`endif

// file: include/acsp_pkg.sv
// Types shared by the two-wire control slave port.
package acsp_pkg;
	typedef enum logic [3:0] {
		ACSP_IDLE      = 4'h0,
		ACSP_ADDR      = 4'h1,
		ACSP_ADDR_ACK  = 4'h3,
		ACSP_SUB       = 4'h2,
		ACSP_SUB_ACK   = 4'h6,
		ACSP_WDATA     = 4'h7,
		ACSP_WDATA_ACK = 4'h5,
		ACSP_RDATA     = 4'h4,
		ACSP_RACK      = 4'hc
	} acsp_state_e;
endpackage : acsp_pkg

// file: dv/acsp_mst.sv
// Bus master model that drives the two-wire link from the far side.
`timescale 1ns/100ps
`default_nettype none
module acsp_mst (
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	localparam time Q = 12;
	// The clock stands still high between frames; data is released high.
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task start();
		sda_drv = 1'b1;
		#Q scl = 1'b1;
		#Q sda_drv = 1'b0;
		#Q scl = 1'b0;
		#Q;
	endtask : start
	task stop();
		sda_drv = 1'b0;
		#Q scl = 1'b1;
		#Q sda_drv = 1'b1;
		#Q;
	endtask : stop
	// Data moves a quarter period after the fall, well clear of the high time.
	task wbyte(input logic [7:0] b, output logic ak);
		for (int i = 7; i >= 0; i--) begin
			sda_drv = b[i];
			#Q scl = 1'b1;
			#(2*Q) scl = 1'b0;
			#Q;
		end
		sda_drv = 1'b1;
		#Q scl = 1'b1;
		#Q ak = ~sda;
		#Q scl = 1'b0;
		#Q;
	endtask : wbyte
	task rbyte(output logic [7:0] b, input logic last);
		sda_drv = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			#Q scl = 1'b1;
			#Q b[i] = sda;
			#Q scl = 1'b0;
			#Q;
		end
		sda_drv = last;
		#Q scl = 1'b1;
		#(2*Q) scl = 1'b0;
		#Q;
	endtask : rbyte
endmodule : acsp_mst
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the two-wire control slave port.
`timescale 1ns/100ps
`default_nettype none
`include "acsp_cfg.svh"
module tb;
	logic         clk;
	logic         nrst;
	logic         ce;
	logic         addr_sel;
	logic         scl;
	logic         m_sda;
	wire logic    sda;
	logic         sda_out;
	logic         sda_oe;
	logic         wr_valid;
	logic [7:0]   wr_addr;
	logic [2:0]   wr_words;
	logic [159:0] wr_data;
	logic [7:0]   rd_addr;
	logic [2:0]   rd_word_idx;
	wire logic [31:0] rd_word;
	logic [6:0]   dev_addr;
	logic         busy;
	int           n_fail;
	int           comparisons;
	int           n_wr;
	int           cyc;
	logic         ok;
	logic [31:0]  v;
	acsp_i2c_slave u_acsp_i2c_slave (.clk(clk), .nrst(nrst), .ce(ce),
		.scl_in(scl), .sda_in(sda), .addr_sel(addr_sel), .sda_out(sda_out),
		.sda_oe(sda_oe), .wr_valid(wr_valid), .wr_addr(wr_addr),
		.wr_words(wr_words), .wr_data(wr_data), .rd_addr(rd_addr),
		.rd_word_idx(rd_word_idx), .rd_word(rd_word), .dev_addr(dev_addr),
		.busy(busy));
	acsp_mst u_acsp_mst (.scl(scl), .sda_drv(m_sda), .sda(sda));
	// Wired-AND with a pull-up: a released line reads high.
	assign sda = (sda_oe === 1'b1) ? (m_sda & sda_out) : m_sda;
	// Low places repeat their byte so any lane choice reads the same value.
	assign rd_word = (rd_addr < 8'h20) ? {4{rd_addr ^ 8'hc3}}
		: {rd_addr, 5'h00, rd_word_idx, 16'h5aa5};
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (wr_valid === 1'b1) n_wr++;
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			conclude();
		end
	end
	task conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk
	task done(input string s);
		$display("test %s finished, %0d mismatches so far", s, n_fail);
	endtask : done
	task rst(input logic s);
		nrst <= 1'b0;
		addr_sel <= s;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (12) @(posedge clk);
	endtask : rst
	task wr(input logic [7:0] a8, input logic [7:0] sub, input int n,
		input logic [63:0] d);
		logic ak;
		// Link edges never land on a rising clk edge so the pins never race the sampler.
		@(negedge clk);
		u_acsp_mst.start();
		u_acsp_mst.wbyte(a8, ak);
		ok = ak;
		u_acsp_mst.wbyte(sub, ak);
		ok &= ak;
		for (int i = n - 1; i >= 0; i--) begin
			u_acsp_mst.wbyte(d[8*(i % 8) +: 8], ak);
			ok &= ak;
		end
		u_acsp_mst.stop();
		repeat (12) @(posedge clk);
	endtask : wr
	task rd(input logic [7:0] a8, input logic [7:0] sub, input int n);
		logic       ak;
		logic [7:0] b;
		v = 32'h0;
		@(negedge clk);
		u_acsp_mst.start();
		u_acsp_mst.wbyte(a8, ak);
		ok = ak;
		u_acsp_mst.wbyte(sub, ak);
		ok &= ak;
		u_acsp_mst.start();
		u_acsp_mst.wbyte(a8 | 8'h01, ak);
		ok &= ak;
		for (int i = 0; i < n; i++) begin
			u_acsp_mst.rbyte(b, i == n - 1);
			v = {v[23:0], b};
		end
		u_acsp_mst.stop();
		repeat (12) @(posedge clk);
	endtask : rd
	initial begin
		n_fail = 0;
		comparisons = 0;
		n_wr = 0;
		cyc = 0;
		nrst = 1'b0;
		ce = 1'b1;
		addr_sel = 1'b1;
		rst(1'b1);
		chk(dev_addr, `ACSP_ADDR_PULLUP);
		rst(1'b0);
		chk(dev_addr, `ACSP_ADDR_PULLDOWN);
		done("strap");
		wr(8'h36, 8'h05, 1, 64'ha7);
		chk({ok, busy, n_wr[7:0]}, 10'h000);
		wr(8'h34, 8'h05, 1, 64'ha7);
		chk({ok, wr_addr, wr_words, wr_data[7:0]},
			{1'b1, 8'h05, 3'h0, 8'ha7});
		wr(8'h34, 8'h10, 2, 64'h1122);
		chk({n_wr[7:0], wr_addr, wr_data[7:0]}, 24'h031122);
		wr(8'h34, 8'h20, 6, 64'h010203040506);
		chk({n_wr[7:0], wr_addr, wr_words, wr_data[31:0]},
			{8'h04, 8'h20, 3'h1, 32'h01020304});
		wr(8'h34, 8'h29, 4, 64'hdeadbeef);
		chk(n_wr, 4);
		done("writes");
		rd(8'h34, 8'h03, 2);
		chk({ok, v}, {1'b1, 32'h0000c0c7});
		rd(8'h34, 8'h20, 4);
		chk(v, 32'h20005aa5);
		done("reads");
		wr(8'h34, `ACSP_SUB_UNLOCK, 4, `ACSP_UNLOCK_KEY);
		wr(8'h34, `ACSP_SUB_NEWADDR, 4, 64'h36);
		chk({n_wr[7:0], 1'b0, dev_addr}, 16'h041b);
		wr(8'h34, 8'h05, 1, 64'ha7);
		chk(ok, 1'b0);
		rd(8'h36, `ACSP_SUB_NEWADDR, 4);
		chk({ok, v}, {1'b1, 32'h00000036});
		done("address change");
		// With the enable low the port must neither answer nor commit.
		ce <= 1'b0;
		wr(8'h36, 8'h07, 1, 64'h55);
		ce <= 1'b1;
		chk({ok, n_wr[7:0]}, 9'h004);
		wr(8'h36, 8'h29, 20, 64'h0123456789abcdef);
		chk({n_wr[7:0], wr_words, wr_addr, wr_data[159:128]},
			{8'h05, 3'h5, 8'h29, 32'h89abcdef});
		chk(wr_data[63:0], 64'h0123456789abcdef);
		rd(8'h36, 8'h29, 8);
		chk(v, 32'h29015aa5);
		done("freeze and filter set");
		conclude();
	end
endmodule : tb
`default_nettype wire
